// ---- core/vrrc_pkg.sv ----
// constants and types shared by the video ram refresh controller
package vrrc_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int ROW_CHARS = 80;
  // upper five address bits that select the two ram banks
  localparam logic [4:0] BANK1_TAG = 5'h02;
  localparam logic [4:0] BANK2_TAG = 5'h03;
  // parameter block and mode line locations inside bank one
  localparam logic [10:0] PARAM_BASE = 11'h000;
  localparam logic [10:0] STATUS_ROW_BASE = 11'h030;
  localparam logic [10:0] STATUS_ROW_LAST = 11'h07f;
  localparam logic [2:0] PARAM_LAST = 3'h5;
  localparam logic [2:0] SLOT_CUR_ROW = 3'h0;
  localparam logic [2:0] SLOT_CUR_COL = 3'h1;
  localparam logic [2:0] SLOT_KEYBOARD = 3'h2;
  localparam logic [2:0] SLOT_FUNCTION = 3'h3;
  localparam logic [2:0] SLOT_EFFECTS = 3'h4;
  localparam logic [2:0] SLOT_PAGE = 3'h5;
  // field geometry
  localparam logic [6:0] COL_LAST = 7'h4f;
  localparam logic [6:0] ROW_FULL = 7'h50;
  localparam logic [4:0] TEXT_ROW_LAST = 5'h17;
  localparam logic [4:0] FIELD_ROWS = 5'h19;
  localparam logic [3:0] LINE_LAST = 4'h9;
  localparam logic [4:0] DISP_ROW_PRE = 5'h1f;
  // control decoder: bits 7..5 equal to this mark a display effects code
  localparam logic [2:0] EFFECT_CODE = 3'h4;
  // register port map
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_CURSOR = 3'h2;
  localparam logic [2:0] REG_FUNC_EFF = 3'h3;
  localparam logic [2:0] REG_PAGE = 3'h4;
  localparam int CTRL_FETCH_EN_BIT = 0;
  localparam logic [15:0] CTRL_RST = 16'h0001;
  typedef enum logic [2:0] {
    VRRC_IDLE = 3'b001,
    VRRC_PARAM = 3'b010,
    VRRC_FETCH = 3'b100
  } vrrc_state_t;
endpackage

// ---- core/vrrc_ram_mux.sv ----
// bank decoder and ram address multiplexer
`timescale 1ns/10ps
module vrrc_ram_mux
  import vrrc_pkg::*;
(
  input wire logic cpuBusReq,
  input wire logic [15:0] busAddr,
  input wire logic refreshReq,
  input wire logic [5:0] refreshAddr,
  input wire logic dispFetch,
  input wire logic [vrrc_pkg::ADDR_W-1:0] dispAddr,
  output logic [vrrc_pkg::ADDR_W-1:0] ramAddr,
  output logic ramCs1,
  output logic ramCs2,
  output logic bufHit
);
  logic hit1;
  logic hit2;

  assign hit1 = busAddr[15:11] == BANK1_TAG;
  assign hit2 = busAddr[15:11] == BANK2_TAG;
  assign bufHit = hit1 | hit2;

  always_comb
  begin
    ramAddr = '0;
    ramCs1 = 1'b0;
    ramCs2 = 1'b0;
    if (cpuBusReq && bufHit)
    begin
      ramAddr = busAddr[10:0];
      ramCs1 = hit1;
      ramCs2 = hit2;
    end
    else if (refreshReq)
    begin
      ramAddr = {5'h00, refreshAddr};
    end
    else if (dispFetch)
    begin
      ramAddr = dispAddr;
      ramCs1 = 1'b1;
    end
  end
endmodule

// ---- core/vrrc_shift80.sv ----
// 80-entry character shift register held in flip-flops
`timescale 1ns/10ps
module vrrc_shift80
  import vrrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic shiftEn,
  input wire logic [vrrc_pkg::DATA_W-1:0] dataIn,
  output logic [vrrc_pkg::DATA_W-1:0] head
);
  logic [DATA_W-1:0] entry_q [ROW_CHARS];

  // each entry moves one place toward the head on a shift
  genvar i;
  generate
    for (i = 0; i < ROW_CHARS; i++)
    begin : g_entry
      always_ff @(posedge core_clk)
      begin
        if (!nrst)
          entry_q[i] <= '0;
        else if (shiftEn)
          entry_q[i] <= (i == ROW_CHARS - 1) ? dataIn : entry_q[(i + 1) % ROW_CHARS];
      end
    end
  endgenerate

  assign head = entry_q[0];
endmodule

// ---- core/vrrc_top.sv ----
// video ram arbitration, parameter read, character fetch and row shifters
// What this block does
// - ram clock gate on refresh, display fetch, or bus address in buffer
// - processor access wins and suppresses display fetches
// - upper five address bits pick bank one or two chip select
// - processor access routes low 11 address bits to the ram
// - buffer read with read strobe drives ram data onto the bus
// - processor write asserts write enable, keeps output off, passes bus data
// - refresh at each horizontal start uses only the 6-bit row address
// - refresh beats display fetch; mux then picks refresh address
// - refresh gates the ram clock for one cycle, bus data ignored
// - all 64 rows refreshed; cpu cycles spaced so refresh fits
// - frame start presets address to parameter block and starts reading
// - six parameter reads in order, address advanced after each of the first five
// - first two reads load cursor row and column
// - third slot writes a pending keyboard character only
// - fourth read loads the function register
// - fifth read decoded into the display effects register
// - sixth read loads page, converts to address, fetching follows
// - 25 rows of 80; first 24 contiguous from page start
// - 25th row always from the fixed mode line range
// - fetched chars fill shifter one; shifter two recirculates nine lines
// - on line ten shifter two loads from shifter one
// - bits 7..5 effect code updates effects and blanks the glyph
// - display fetches only on alternate memory cycles
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module vrrc_top
  import vrrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cpuBusReq,
  input wire logic [15:0] busAddr,
  input wire logic busRd,
  input wire logic busWr,
  input wire logic [vrrc_pkg::DATA_W-1:0] busDataIn,
  output logic [vrrc_pkg::DATA_W-1:0] busDataOut,
  output logic busDataOe_n,
  input wire logic refreshReq,
  input wire logic [5:0] refreshAddr,
  input wire logic frameStart,
  input wire logic charShift,
  input wire logic lineEnd,
  input wire logic kbdPending,
  input wire logic [vrrc_pkg::DATA_W-1:0] kbdChar,
  output logic kbdWritten,
  output logic [vrrc_pkg::ADDR_W-1:0] ramAddr,
  output logic ramCs1,
  output logic ramCs2,
  output logic ramClkGate,
  output logic ramWe,
  output logic [vrrc_pkg::DATA_W-1:0] ramDataOut,
  input wire logic [vrrc_pkg::DATA_W-1:0] ramDataIn,
  output logic [vrrc_pkg::DATA_W-1:0] charOut_q,
  output logic charValid_q,
  output logic cursorOn_q,
  output logic [4:0] effects_q,
  output logic [vrrc_pkg::DATA_W-1:0] function_q,
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData_q
);
  import vrrc_pkg::*;

  vrrc_state_t state_q;
  logic phase_q;
  logic [2:0] paramIdx_q;
  logic [ADDR_W-1:0] dispAddr_q;
  logic [DATA_W-1:0] cursorRow_q;
  logic [DATA_W-1:0] cursorCol_q;
  logic [4:0] page_q;
  logic [6:0] fetchCol_q;
  logic [4:0] fetchRow_q;
  logic [6:0] fillCnt_q;
  logic [3:0] lineCnt_q;
  logic [4:0] dispRow_q;
  logic [6:0] dispCol_q;
  logic [15:0] ctrl_q;
  logic fetchAllowed;
  logic dispFetch;
  logic paramRead;
  logic charFetch;
  logic kbdSlot;
  logic bufHit;
  logic cpuHit;
  logic transferLine;
  logic sr1Shift;
  logic [DATA_W-1:0] sr1In;
  logic [DATA_W-1:0] sr1Head;
  logic [DATA_W-1:0] sr2In;
  logic [DATA_W-1:0] sr2Head;
  logic [ADDR_W-1:0] pageAddr;

  // fetch gating for each phase of the frame
  always_comb
  begin
    fetchAllowed = 1'b0;
    unique case (state_q)
      VRRC_IDLE: fetchAllowed = 1'b0;
      VRRC_PARAM: fetchAllowed = 1'b1;
      VRRC_FETCH: fetchAllowed = ctrl_q[CTRL_FETCH_EN_BIT] && (fillCnt_q != ROW_FULL)
        && !(transferLine && charShift) && (fetchRow_q != FIELD_ROWS);
    endcase
  end

  assign dispFetch = phase_q && fetchAllowed && !cpuBusReq && !refreshReq;
  assign paramRead = dispFetch && (state_q == VRRC_PARAM);
  assign charFetch = dispFetch && (state_q == VRRC_FETCH);
  assign kbdSlot = paramRead && (paramIdx_q == SLOT_KEYBOARD);
  assign cpuHit = cpuBusReq && bufHit;
  assign transferLine = lineCnt_q == LINE_LAST;
  assign pageAddr = {ramDataIn[4:0], 6'h00} + {2'h0, ramDataIn[4:0], 4'h0};

  vrrc_ram_mux u_mux (
    .cpuBusReq(cpuBusReq),
    .busAddr(busAddr),
    .refreshReq(refreshReq),
    .refreshAddr(refreshAddr),
    .dispFetch(dispFetch),
    .dispAddr(dispAddr_q),
    .ramAddr(ramAddr),
    .ramCs1(ramCs1),
    .ramCs2(ramCs2),
    .bufHit(bufHit)
  );

  // clock gate, one memory cycle per refresh request
  assign ramClkGate = refreshReq || dispFetch || cpuHit;
  // write enable and ram input multiplexer
  assign ramWe = (cpuHit && busWr) || (kbdSlot && kbdPending && !cpuBusReq);
  assign ramDataOut = cpuBusReq ? busDataIn : kbdChar;
  // read data gate onto the system bus
  assign busDataOe_n = !(cpuHit && busRd && !busWr);
  assign busDataOut = busDataOe_n ? '0 : ramDataIn;
  assign kbdWritten = kbdSlot && kbdPending;

  // frame sequencer
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state_q <= VRRC_IDLE;
    else if (frameStart)
      state_q <= VRRC_PARAM;
    else if (paramRead && paramIdx_q == PARAM_LAST)
      state_q <= VRRC_FETCH;
  end

  // fetch slot toggles every memory cycle while active
  always_ff @(posedge core_clk)
  begin
    if (!nrst || frameStart)
      phase_q <= 1'b0;
    else if (state_q != VRRC_IDLE)
      phase_q <= !phase_q;
  end

  // parameter index and display address counter
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      paramIdx_q <= '0;
      dispAddr_q <= PARAM_BASE;
    end
    else if (frameStart)
    begin
      paramIdx_q <= '0;
      dispAddr_q <= PARAM_BASE;
    end
    else if (paramRead)
    begin
      paramIdx_q <= paramIdx_q + 3'h1;
      // page row converted to a binary address
      if (paramIdx_q == SLOT_PAGE)
        dispAddr_q <= pageAddr;
      else
        dispAddr_q <= dispAddr_q + 11'h001;
    end
    else if (charFetch)
    begin
      // text rows run on, mode line has a fixed base
      if (fetchRow_q == TEXT_ROW_LAST && fetchCol_q == COL_LAST)
        dispAddr_q <= STATUS_ROW_BASE;
      else
        dispAddr_q <= dispAddr_q + 11'h001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cursorRow_q <= '0;
      cursorCol_q <= '0;
      function_q <= '0;
      page_q <= '0;
    end
    else if (paramRead)
    begin
      if (paramIdx_q == SLOT_CUR_ROW)
        cursorRow_q <= ramDataIn;
      if (paramIdx_q == SLOT_CUR_COL)
        cursorCol_q <= ramDataIn;
      if (paramIdx_q == SLOT_FUNCTION)
        function_q <= ramDataIn;
      if (paramIdx_q == SLOT_PAGE)
        page_q <= ramDataIn[4:0];
    end
  end

  // effects from the fifth parameter and from effect codes
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      effects_q <= '0;
    else if (paramRead && paramIdx_q == SLOT_EFFECTS)
      effects_q <= ramDataIn[4:0];
    else if (charShift && sr2Head[7:5] == EFFECT_CODE)
      effects_q <= sr2Head[4:0];
  end

  // row and column of the fetch stream
  always_ff @(posedge core_clk)
  begin
    if (!nrst || frameStart)
    begin
      fetchCol_q <= '0;
      fetchRow_q <= '0;
    end
    else if (charFetch)
    begin
      if (fetchCol_q == COL_LAST)
      begin
        fetchCol_q <= '0;
        fetchRow_q <= fetchRow_q + 5'h01;
      end
      else
        fetchCol_q <= fetchCol_q + 7'h01;
    end
  end

  // shifter one fill count, emptied by the row transfer
  always_ff @(posedge core_clk)
  begin
    if (!nrst || frameStart)
      fillCnt_q <= '0;
    else if (lineEnd && transferLine)
      fillCnt_q <= '0;
    else if (charFetch)
      fillCnt_q <= fillCnt_q + 7'h01;
  end

  // scan line and display row counters; first line of a field loads row one
  always_ff @(posedge core_clk)
  begin
    if (!nrst || frameStart)
    begin
      lineCnt_q <= LINE_LAST;
      dispRow_q <= DISP_ROW_PRE;
    end
    else if (lineEnd)
    begin
      if (transferLine)
      begin
        lineCnt_q <= '0;
        dispRow_q <= dispRow_q + 5'h01;
      end
      else
        lineCnt_q <= lineCnt_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst || lineEnd)
      dispCol_q <= '0;
    else if (charShift)
      dispCol_q <= dispCol_q + 7'h01;
  end

  // shifter one takes ram data, shifter two recirculates or loads
  assign sr1Shift = charFetch || (charShift && transferLine);
  assign sr1In = charFetch ? ramDataIn : '0;
  assign sr2In = transferLine ? sr1Head : sr2Head;

  vrrc_shift80 u_sr1 (
    .core_clk(core_clk),
    .nrst(nrst),
    .shiftEn(sr1Shift),
    .dataIn(sr1In),
    .head(sr1Head)
  );

  vrrc_shift80 u_sr2 (
    .core_clk(core_clk),
    .nrst(nrst),
    .shiftEn(charShift),
    .dataIn(sr2In),
    .head(sr2Head)
  );

  // character generator feed and cursor overlay
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      charOut_q <= '0;
      charValid_q <= 1'b0;
      cursorOn_q <= 1'b0;
    end
    else
    begin
      charValid_q <= charShift && sr2Head[7:5] != EFFECT_CODE;
      if (charShift)
      begin
        charOut_q <= (sr2Head[7:5] == EFFECT_CODE) ? '0 : sr2Head;
        cursorOn_q <= {3'h0, dispRow_q} == cursorRow_q && {1'b0, dispCol_q} == cursorCol_q;
      end
    end
  end

  // register port: control write, state readback
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      ctrl_q <= CTRL_RST;
    else if (regWr && regAddr == REG_CTRL)
      ctrl_q <= regWrData;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      regRdData_q <= '0;
    else if (regRd)
    begin
      unique case (regAddr)
        REG_CTRL: regRdData_q <= ctrl_q;
        REG_STATUS: regRdData_q <= {4'h0, state_q, fetchRow_q, lineCnt_q};
        REG_CURSOR: regRdData_q <= {cursorRow_q, cursorCol_q};
        REG_FUNC_EFF: regRdData_q <= {function_q, 3'h0, effects_q};
        REG_PAGE: regRdData_q <= {11'h000, page_q};
        default: regRdData_q <= '0;
      endcase
    end
    else
      regRdData_q <= '0;
  end

  cpu_prio_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cpuBusReq |-> !dispFetch && !(ramCs1 && !bufHit && busAddr[15:11] != BANK1_TAG))
    else $error("display fetch during cpu access");
  refresh_prio_a: assert property (@(posedge core_clk) disable iff (!nrst)
    refreshReq && !cpuHit |-> !dispFetch && ramAddr == {5'h00, refreshAddr})
    else $error("refresh address not selected");
  clk_gate_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (refreshReq || dispFetch || cpuHit) |-> ramClkGate)
    else $error("ram clock gate missing");
  bus_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cpuHit && busRd && !busWr |-> !busDataOe_n && busDataOut == ramDataIn && !ramWe)
    else $error("buffer read not driven");
  bus_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cpuHit && busWr |-> ramWe && busDataOe_n && ramDataOut == busDataIn)
    else $error("buffer write path wrong");
  cpu_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cpuHit |-> ramAddr == busAddr[10:0] && (ramCs1 != ramCs2))
    else $error("cpu address not routed");
  alt_fetch_a: assert property (@(posedge core_clk) disable iff (!nrst)
    dispFetch && !frameStart |=> !dispFetch)
    else $error("back to back display fetch");
  frame_preset_a: assert property (@(posedge core_clk) disable iff (!nrst)
    frameStart |=> state_q == VRRC_PARAM && dispAddr_q == PARAM_BASE && paramIdx_q == 3'h0)
    else $error("frame start preset wrong");
  param_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
    paramRead && paramIdx_q != PARAM_LAST && !frameStart
      |=> paramIdx_q == $past(paramIdx_q) + 3'h1 && dispAddr_q == $past(dispAddr_q) + 11'h001)
    else $error("parameter step wrong");
  page_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
    paramRead && paramIdx_q == SLOT_PAGE && !frameStart
      |=> state_q == VRRC_FETCH && page_q == $past(ramDataIn[4:0]))
    else $error("page load wrong");
  mode_line_a: assert property (@(posedge core_clk) disable iff (!nrst)
    charFetch && fetchRow_q == FIELD_ROWS - 5'h01 |-> dispAddr_q >= STATUS_ROW_BASE
      && dispAddr_q <= STATUS_ROW_LAST)
    else $error("mode line address out of range");
endmodule

// ---- sim/tb_video_ram_refresh_controller.sv ----
// self-checking bench for the video ram refresh controller
`timescale 1ns/10ps
module tb_video_ram_refresh_controller;
  import vrrc_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, cpuBusReq = 1'b0, busRd = 1'b0, busWr = 1'b0;
  logic [15:0] busAddr = 16'h0000, regWrData = 16'h0000;
  logic [7:0] busDataIn = 8'h00, kbdChar = 8'h00, busDataOut, ramDataOut, ramDataIn;
  logic refreshReq = 1'b0, frameStart = 1'b0, charShift = 1'b0, lineEnd = 1'b0;
  logic [5:0] refreshAddr = 6'h00;
  logic kbdPending = 1'b0, regWr = 1'b0, regRd = 1'b0, capOn = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic busDataOe_n, kbdWritten, ramCs1, ramCs2, ramClkGate, ramWe, charValid_q, cursorOn_q;
  logic [10:0] ramAddr;
  logic [7:0] charOut_q, function_q;
  logic [4:0] effects_q;
  logic [15:0] regRdData_q, rd;
  logic [10:0] capA [$];
  int capT [$];
  int cyc = 0, n_checks = 0, n_mismatch = 0;
  always #5 core_clk = ~core_clk;
  vrrc_top vrrc_top_i (.core_clk, .nrst, .cpuBusReq, .busAddr, .busRd, .busWr, .busDataIn,
    .busDataOut, .busDataOe_n, .refreshReq, .refreshAddr, .frameStart, .charShift, .lineEnd,
    .kbdPending, .kbdChar, .kbdWritten, .ramAddr, .ramCs1, .ramCs2, .ramClkGate, .ramWe,
    .ramDataOut, .ramDataIn, .charOut_q, .charValid_q, .cursorOn_q, .effects_q, .function_q,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData_q);
  vrrc_ram_model vrrc_ram_model_i (.core_clk, .ramAddr, .ramCs1, .ramCs2, .ramClkGate,
    .ramWe, .ramDataOut, .ramDataIn);
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (capOn && ramClkGate && !cpuBusReq && !refreshReq)
    begin
      capA.push_back(ramAddr);
      capT.push_back(cyc);
    end
  end
  task automatic chkF(input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic chkD(input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic regRead(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData_q;
  endtask
  task automatic regWrite(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  // one processor cycle, then two idle memory cycles
  task automatic cpuAcc(input logic [15:0] a, input logic wr, input logic [7:0] d,
    input logic chk);
    logic hit;
    hit = (a[15:11] == BANK1_TAG) || (a[15:11] == BANK2_TAG);
    @(posedge core_clk);
    cpuBusReq <= 1'b1;
    busAddr <= a;
    busWr <= wr;
    busRd <= !wr;
    busDataIn <= d;
    #1;
    if (chk)
    begin
      chkF(hit, ramClkGate);
      chkF(a[15:11] == BANK1_TAG, ramCs1);
      chkF(a[15:11] == BANK2_TAG, ramCs2);
      if (hit)
        chkD(16'(a[10:0]), 16'(ramAddr));
      chkF(!(hit && !wr), busDataOe_n);
      chkF(hit && wr, ramWe);
      if (hit && wr)
        chkD(16'(d), 16'(ramDataOut));
      if (hit && !wr)
        chkD(16'(d), 16'(busDataOut));
    end
    @(posedge core_clk);
    cpuBusReq <= 1'b0;
    busWr <= 1'b0;
    busRd <= 1'b0;
    busAddr <= 16'h0000;
    @(posedge core_clk);
  endtask
  task automatic t_regs();
    regRead(REG_STATUS, rd);
    chkD(16'h0209, rd);
    regWrite(REG_CTRL, 16'h5a00);
    regRead(REG_CTRL, rd);
    chkD(16'h5a00, rd);
    regWrite(REG_CTRL, CTRL_RST);
    regRead(REG_CTRL, rd);
    chkD(CTRL_RST, rd);
    regRead(3'h6, rd);
    chkD(16'h0000, rd);
    $display("test regs done");
  endtask
  task automatic t_cpu();
    cpuAcc(16'h1123, 1'b1, 8'h5c, 1'b1);
    cpuAcc(16'h1923, 1'b1, 8'ha7, 1'b1);
    cpuAcc(16'h1123, 1'b0, 8'h5c, 1'b1);
    cpuAcc(16'h1923, 1'b0, 8'ha7, 1'b1);
    cpuAcc(16'h2123, 1'b0, 8'h00, 1'b1);
    $display("test cpu done");
  endtask
  task automatic t_refresh();
    @(posedge core_clk);
    refreshReq <= 1'b1;
    refreshAddr <= 6'h2a;
    #1 chkD(16'h002a, 16'(ramAddr));
    chkF(1'b1, ramClkGate);
    chkF(1'b0, ramWe);
    @(posedge core_clk);
    refreshReq <= 1'b0;
    #1 chkF(1'b0, ramClkGate);
    $display("test refresh done");
  endtask
  task automatic t_frame();
    logic [10:0] expA [8] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h005,
      11'h0a0, 11'h0a1};
    int k;
    cpuAcc(16'h1000, 1'b1, 8'h00, 1'b0);
    cpuAcc(16'h1001, 1'b1, 8'h05, 1'b0);
    cpuAcc(16'h1003, 1'b1, 8'ha5, 1'b0);
    cpuAcc(16'h1004, 1'b1, 8'h93, 1'b0);
    cpuAcc(16'h1005, 1'b1, 8'h02, 1'b0);
    for (int i = 0; i < 80; i++)
      cpuAcc(16'h10a0 + 16'(i), 1'b1, (i == 1) ? 8'h8b : 8'h20 + 8'(i), 1'b0);
    @(posedge core_clk);
    capOn <= 1'b1;
    frameStart <= 1'b1;
    kbdPending <= 1'b1;
    kbdChar <= 8'h6b;
    @(posedge core_clk);
    frameStart <= 1'b0;
    k = 0;
    while (kbdWritten !== 1'b1 && k < 40)
    begin
      @(posedge core_clk);
      k++;
    end
    kbdPending <= 1'b0;
    // eight gated reads land on alternate edges; stop on a fetch slot
    repeat (11) @(posedge core_clk);
    // processor request suppresses the fetch slot
    cpuBusReq <= 1'b1;
    busAddr <= 16'h2000;
    busRd <= 1'b1;
    #1 chkF(1'b0, ramClkGate);
    @(posedge core_clk);
    cpuBusReq <= 1'b0;
    busRd <= 1'b0;
    busAddr <= 16'h0000;
    @(posedge core_clk);
    refreshReq <= 1'b1;
    refreshAddr <= 6'h15;
    #1 chkD(16'h0015, 16'(ramAddr));
    @(posedge core_clk);
    refreshReq <= 1'b0;
    chkD(16'd8, 16'(capA.size()));
    for (int i = 0; i < 8 && i < capA.size(); i++)
    begin
      chkD(16'(expA[i]), 16'(capA[i]));
      if (i > 0)
        chkD(16'd2, 16'(capT[i] - capT[i-1]));
    end
    chkD(16'h006b, 16'(vrrc_ram_model_i.mem1[2]));
    chkD(16'h00a5, 16'(function_q));
    chkD(16'h0013, 16'(effects_q));
    regRead(REG_CURSOR, rd);
    chkD(16'h0005, rd);
    regRead(REG_PAGE, rd);
    chkD(16'h0002, rd);
    regRead(REG_FUNC_EFF, rd);
    chkD(16'ha513, rd);
    $display("test frame done");
  endtask
  task automatic shiftOne();
    @(posedge core_clk);
    charShift <= 1'b1;
    @(posedge core_clk);
    charShift <= 1'b0;
    #1;
  endtask
  task automatic endLine();
    @(posedge core_clk);
    lineEnd <= 1'b1;
    @(posedge core_clk);
    lineEnd <= 1'b0;
  endtask
  task automatic t_shift();
    repeat (200) @(posedge core_clk);
    // transfer line moves shifter one into shifter two
    repeat (80) shiftOne();
    endLine();
    for (int c = 0; c < 80; c++)
    begin
      shiftOne();
      if (c < 8)
      begin
        chkF(c != 1, charValid_q);
        chkD((c == 1) ? 16'h0000 : 16'h0020 + 16'(c), 16'(charOut_q));
        chkF(c == 5, cursorOn_q);
        if (c > 1)
          chkD(16'h000b, 16'(effects_q));
      end
    end
    endLine();
    shiftOne();
    chkD(16'h0020, 16'(charOut_q));
    $display("test shift done");
  endtask
  task automatic t_mode();
    capA.delete();
    capT.delete();
    // run the fetch stream through rows two to twenty-four
    for (int r = 0; r < 23; r++)
    begin
      repeat (10) endLine();
      repeat (170) @(posedge core_clk);
    end
    chkD(16'd1840, 16'(capA.size()));
    if (capA.size() == 1840)
    begin
      chkD(16'h0140, 16'(capA[0]));
      chkD(16'h001f, 16'(capA[1759]));
      for (int i = 0; i < 80; i++)
        chkD(16'h0030 + 16'(i), 16'(capA[1760 + i]));
    end
    regRead(REG_STATUS, rd);
    chkD(16'h0991, rd);
    $display("test mode line done");
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_cpu();
    t_refresh();
    t_frame();
    t_shift();
    t_mode();
    conclude();
  end
endmodule

// ---- sim/vrrc_ram_model.sv ----
// dynamic ram array model behind the video controller
`timescale 1ns/10ps
module vrrc_ram_model
  import vrrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [vrrc_pkg::ADDR_W-1:0] ramAddr,
  input wire logic ramCs1,
  input wire logic ramCs2,
  input wire logic ramClkGate,
  input wire logic ramWe,
  input wire logic [vrrc_pkg::DATA_W-1:0] ramDataOut,
  output logic [vrrc_pkg::DATA_W-1:0] ramDataIn
);
  logic [7:0] mem1 [2048];
  logic [7:0] mem2 [2048];
  logic [7:0] lastQ = 8'h00;
  initial
  begin
    for (int i = 0; i < 2048; i++)
    begin
      mem1[i] = 8'h00;
      mem2[i] = 8'h00;
    end
  end
  // gated write cycles store to the selected array
  always @(posedge core_clk)
  begin
    if (ramClkGate && ramWe && ramCs1)
      mem1[ramAddr] <= ramDataOut;
    if (ramClkGate && ramWe && ramCs2)
      mem2[ramAddr] <= ramDataOut;
    if (ramCs1 || ramCs2)
      lastQ <= ramDataIn;
  end
  // unselected array shows inverse of last value
  always_comb
  begin
    if (ramCs1)
      ramDataIn = mem1[ramAddr];
    else if (ramCs2)
      ramDataIn = mem2[ramAddr];
    else
      ramDataIn = ~lastQ;
  end
endmodule
